// file: hw/mmcr_defs.svh
// Constants for the media mode control register bank and its management port.
`ifndef MMCR_DEFS_SVH
`define MMCR_DEFS_SVH

// Register addresses on the management port.
`define MMCR_ADDR_BASIC_CTRL  5'h00
`define MMCR_ADDR_MODE_CTRL   5'h17

// Software reset bit in the basic control register.
`define MMCR_SWRST_BIT        15

// Field positions in the media mode control register.
`define MMCR_RSVD_RW_HI       15
`define MMCR_RSVD_RW_LO       14
`define MMCR_PEND_HI          13
`define MMCR_PEND_LO          8
`define MMCR_MAC_IF_BIT       12
`define MMCR_PREF_BIT         11
`define MMCR_MEDIA_HI         10
`define MMCR_MEDIA_LO         8
`define MMCR_OVR_HI           7
`define MMCR_OVR_LO           6
`define MMCR_FELB_BIT         3

// Reset values of the fields.
`define MMCR_RST_PEND         6'h00
`define MMCR_RST_RSVD_RW      2'h0
`define MMCR_RST_OVR          2'h0
`define MMCR_RST_FELB         1'h0
`define MMCR_RD_IDLE          16'h0000

// Media operating mode codes.
`define MMCR_MEDIA_COPPER     3'h0
`define MMCR_MEDIA_PTM        3'h1
`define MMCR_MEDIA_1000X      3'h2
`define MMCR_MEDIA_100FX      3'h3
`define MMCR_MEDIA_RSVD       3'h4
`define MMCR_MEDIA_SENSE_PTM    3'h5
`define MMCR_MEDIA_SENSE_1000X  3'h6
`define MMCR_MEDIA_SENSE_100FX  3'h7

// Automatic media sense override codes.
`define MMCR_OVR_NORMAL       2'h0
`define MMCR_OVR_SERDES       2'h1
`define MMCR_OVR_COPPER       2'h2

// Global serdes field value that allows the 1000BASE-X MAC choice.
`define MMCR_SERDES_CFG_OK    2'h0

// Management frame layout.
`define MMCR_PREAMBLE_BITS    6'd32
`define MMCR_HDR_BITS         5'd13
`define MMCR_DATA_BITS        5'd16
`define MMCR_OP_READ          2'h2
`define MMCR_OP_WRITE         2'h1

`endif

// file: hw/mmcr_pkg.sv
// Types shared by the media mode control register bank.
package mmcr_pkg;

  // Mode configuration as seen by the port datapath.
  typedef struct packed {
    logic       mac_1000bx;
    logic       mac_1000bx_valid;
    logic       copper_preferred;
    logic [2:0] media_mode;
    logic       automatic_media_sense;
    logic       media_mode_reserved;
    logic [1:0] sense_override;
    logic       far_end_loopback;
  } mmcr_mode_t;

  // Management frame write request handed to the register bank.
  typedef struct packed {
    logic        wr_en;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } mmcr_mgmt_req_t;

  // Media chosen for the port.
  typedef enum logic [1:0] {
    MMCR_SEL_NONE,
    MMCR_SEL_COPPER,
    MMCR_SEL_SERDES
  } mmcr_media_sel_t;

endpackage

// file: hw/mmcr_smi_slave.sv
// Serial management frame decoder for one PHY address.
`timescale 1ns/1ps
`include "mmcr_defs.svh"

module mmcr_smi_slave (
  // Clock and reset.
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  // Station address of this port.
  input  wire logic [4:0]              phy_addr,
  // Management pins.
  input  wire logic                    mdc,
  input  wire logic                    mdio_in,
  output logic                         mdio_out,
  output logic                         mdio_oe_n,
  // Register bank side.
  output mmcr_pkg::mmcr_mgmt_req_t     req,
  input  wire logic [15:0]             rd_data
);
  import mmcr_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_TA, ST_DATA} mmcr_smi_st_t;

  logic [1:0]   mdc_sync_reg;    // Pin synchroniser for the management clock.
  logic [1:0]   mdio_sync_reg;   // Pin synchroniser for the data line.
  logic         mdc_last_reg;    // Previous synchronised clock level.
  logic         rise;            // One-cycle pulse on a rising management clock.
  logic         bit_in;          // Synchronised data line level.
  mmcr_smi_st_t st_reg;          // Frame phase.
  logic [5:0]   ones_reg;        // Consecutive preamble ones seen.
  logic [4:0]   cnt_reg;         // Bits taken in the current phase.
  logic [12:0]  hdr_reg;         // Start bit, opcode, PHY and register address.
  logic [15:0]  shift_reg;       // Write data in, or read data out.
  logic         hit;             // Frame is for this PHY.

  // Two flip-flops on each pin; only the second stage feeds logic.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mdc_sync_reg  <= 2'h0;
      mdio_sync_reg <= 2'h3;
      mdc_last_reg  <= 1'h0;
    end else begin
      mdc_sync_reg  <= {mdc_sync_reg[0], mdc};
      mdio_sync_reg <= {mdio_sync_reg[0], mdio_in};
      mdc_last_reg  <= mdc_sync_reg[1];
    end
  end

  assign rise   = mdc_sync_reg[1] & ~mdc_last_reg;
  assign bit_in = mdio_sync_reg[1];
  assign hit    = (hdr_reg[9:5] == phy_addr);

  // Frame walker. The line is driven right after a rising edge so that the
  // station sees stable data at its next rising edge; this trades a half clock
  // of margin for a single-edge design.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_reg    <= ST_IDLE;
      ones_reg  <= 6'h00;
      cnt_reg   <= 5'h00;
      hdr_reg   <= 13'h0000;
      shift_reg <= 16'h0000;
      mdio_out  <= 1'h1;
      mdio_oe_n <= 1'h1;
      req       <= '0;
    end else begin
      req.wr_en <= 1'h0;
      if (rise) begin
        case (st_reg)
          ST_IDLE: begin
            // A zero after a full preamble is the first start bit.
            if (bit_in) begin
              if (ones_reg != `MMCR_PREAMBLE_BITS) begin
                ones_reg <= ones_reg + 6'h01;
              end
            end else begin
              if (ones_reg == `MMCR_PREAMBLE_BITS) begin
                st_reg  <= ST_HDR;
                cnt_reg <= 5'h01;
                hdr_reg <= 13'h0000;
              end
              ones_reg <= 6'h00;
            end
          end
          ST_HDR: begin
            hdr_reg <= {hdr_reg[11:0], bit_in};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == `MMCR_HDR_BITS) begin
              st_reg   <= ST_TA;
              cnt_reg  <= 5'h00;
              // Publish the register address now, so the bank has the read word
              // ready at the turnaround; it is only acted on with wr_en.
              req.addr <= {hdr_reg[3:0], bit_in};
            end
          end
          ST_TA: begin
            // Take the read word now and drive the second turnaround zero.
            if (hdr_reg[12] && hdr_reg[11:10] == `MMCR_OP_READ && hit) begin
              shift_reg <= rd_data;
              mdio_out  <= 1'h0;
              mdio_oe_n <= 1'h0;
            end
            st_reg  <= ST_DATA;
            cnt_reg <= 5'h00;
          end
          ST_DATA: begin
            // Turnaround second bit is consumed when cnt_reg is zero.
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg != 5'h00) begin
              shift_reg <= {shift_reg[14:0], bit_in};
            end
            // Every edge from the second turnaround bit on puts out the next
            // read bit, so the word must move on at each of them.
            if (!mdio_oe_n) begin
              mdio_out  <= (cnt_reg == `MMCR_DATA_BITS) ? 1'h1 : shift_reg[15];
              shift_reg <= {shift_reg[14:0], 1'h0};
            end
            if (cnt_reg == `MMCR_DATA_BITS) begin
              st_reg    <= ST_IDLE;
              mdio_oe_n <= 1'h1;
              mdio_out  <= 1'h1;
              if (hdr_reg[12] && hdr_reg[11:10] == `MMCR_OP_WRITE && hit) begin
                req.wr_en <= 1'h1;
                req.addr  <= hdr_reg[4:0];
                req.wdata <= {shift_reg[14:0], bit_in};
              end
            end
          end
          default: begin
            st_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// file: hw/mmcr_top.sv
// Media mode control register bank for one PHY port.
//
// How it works
// - Bit 12 picks SGMII or 1000BASE-X MAC.
// - Bit 11 picks copper or fiber preference.
// - Codes 000-011 select one fixed media.
// - Codes 101-111 enable automatic media sense; 100 reserved.
// - Bits 7:6 force serdes, copper, or normal.
// - Bit 3 enables far-end loopback, resets off.
// - Bits 13:8 apply only after software reset.
// - Reads return mode in effect, not pending.
// - Super-sticky fields survive software reset always.
`timescale 1ns/1ps
`include "mmcr_defs.svh"

module mmcr_top (
  // Clock and reset.
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  // Management pins and station address.
  input  wire logic [4:0]              phy_addr,
  input  wire logic                    mdc,
  input  wire logic                    mdio_in,
  output logic                         mdio_out,
  output logic                         mdio_oe_n,
  // Global serdes field and media presence pins.
  input  wire logic [1:0]              serdes_cfg,
  input  wire logic                    copper_link_up,
  input  wire logic                    fiber_signal_detect,
  // Mode outputs to the port datapath.
  output mmcr_pkg::mmcr_mode_t         mode,
  output mmcr_pkg::mmcr_media_sel_t    media_sel,
  output logic                         sw_reset_pulse
);
  import mmcr_pkg::*;

  mmcr_mgmt_req_t req;                 // Write request from the frame decoder.
  logic [15:0]    rd_data;             // Read word for the addressed register.
  logic [5:0]     pend_reg;            // Pending bits 13:8 as last written.
  logic [5:0]     act_reg;             // Bits 13:8 currently in effect.
  logic [1:0]     rsvd_rw_reg;         // Reserved writable bits 15:14.
  logic [1:0]     ovr_reg;             // Automatic media sense override.
  logic           felb_reg;            // Far-end loopback enable.
  logic           wr_mode;             // Write to the mode register.
  logic           swrst;               // Software reset request.
  logic [1:0]     cfg_sync_reg [2];    // Synchroniser for the global field.
  logic [1:0]     det_sync_reg [2];    // Synchronisers for presence pins.
  logic [1:0]     det_q;               // Synchronised presence: {fiber, copper}.
  mmcr_media_sel_t sel_next;           // Next media choice.

  // Serial management frames come in through the decoder.
  mmcr_smi_slave i_mmcr_smi_slave (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .phy_addr  (phy_addr),
    .mdc       (mdc),
    .mdio_in   (mdio_in),
    .mdio_out  (mdio_out),
    .mdio_oe_n (mdio_oe_n),
    .req       (req),
    .rd_data   (rd_data)
  );

  assign wr_mode = req.wr_en && req.addr == `MMCR_ADDR_MODE_CTRL;
  assign swrst   = req.wr_en && req.addr == `MMCR_ADDR_BASIC_CTRL && req.wdata[`MMCR_SWRST_BIT];

  // Software reset pulse for the rest of the port; it lasts one cycle.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sw_reset_pulse <= 1'h0;
    end else begin
      sw_reset_pulse <= swrst;
    end
  end

  // Pending mode bits take each write at once but do not act yet.
  // Being super-sticky, they keep their value over a software reset.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pend_reg <= `MMCR_RST_PEND;
    end else if (wr_mode) begin
      pend_reg <= req.wdata[`MMCR_PEND_HI:`MMCR_PEND_LO];
    end
  end

  // The acting copy loads only on software reset, so a mode change is
  // never seen halfway through a link; a write in the same frame as the
  // reset cannot occur since one frame carries one register.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      act_reg <= `MMCR_RST_PEND;
    end else if (swrst) begin
      act_reg <= pend_reg;
    end
  end

  // Non-sticky fields return to their defaults on a software reset.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rsvd_rw_reg <= `MMCR_RST_RSVD_RW;
      ovr_reg     <= `MMCR_RST_OVR;
      felb_reg    <= `MMCR_RST_FELB;
    end else if (swrst) begin
      rsvd_rw_reg <= `MMCR_RST_RSVD_RW;
      ovr_reg     <= `MMCR_RST_OVR;
      felb_reg    <= `MMCR_RST_FELB;
    end else if (wr_mode) begin
      rsvd_rw_reg <= req.wdata[`MMCR_RSVD_RW_HI:`MMCR_RSVD_RW_LO];
      ovr_reg     <= req.wdata[`MMCR_OVR_HI:`MMCR_OVR_LO];
      felb_reg    <= req.wdata[`MMCR_FELB_BIT];
    end
  end

  // Read word: the acting mode bits, never the pending ones, and zero in
  // the read-only reserved places. Unmapped addresses read as zero.
  always_comb begin
    rd_data = `MMCR_RD_IDLE;
    // The decoder publishes the register address at the end of the header.
    if (req.addr == `MMCR_ADDR_MODE_CTRL) begin
      rd_data[`MMCR_RSVD_RW_HI:`MMCR_RSVD_RW_LO] = rsvd_rw_reg;
      rd_data[`MMCR_PEND_HI:`MMCR_PEND_LO]       = act_reg;
      rd_data[`MMCR_OVR_HI:`MMCR_OVR_LO]         = ovr_reg;
      rd_data[`MMCR_FELB_BIT]                    = felb_reg;
    end
  end

  // Two-stage synchronisers on the global field and presence pins.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cfg_sync_reg[0] <= 2'h0;
      cfg_sync_reg[1] <= 2'h0;
      det_sync_reg[0] <= 2'h0;
      det_sync_reg[1] <= 2'h0;
    end else begin
      cfg_sync_reg[0] <= serdes_cfg;
      cfg_sync_reg[1] <= cfg_sync_reg[0];
      det_sync_reg[0] <= {fiber_signal_detect, copper_link_up};
      det_sync_reg[1] <= det_sync_reg[0];
    end
  end

  assign det_q = det_sync_reg[1];

  // Decoded mode for the datapath: bits 12:8 from the acting copy, override and loopback from their registers.
  always_comb begin
    mode                       = '0;
    mode.mac_1000bx            = act_reg[`MMCR_MAC_IF_BIT - `MMCR_PEND_LO];
    mode.mac_1000bx_valid      = mode.mac_1000bx && cfg_sync_reg[1] == `MMCR_SERDES_CFG_OK;
    mode.copper_preferred      = act_reg[`MMCR_PREF_BIT - `MMCR_PEND_LO];
    mode.media_mode            = act_reg[`MMCR_MEDIA_HI - `MMCR_PEND_LO:0];
    mode.automatic_media_sense = mode.media_mode >= `MMCR_MEDIA_SENSE_PTM;
    mode.media_mode_reserved   = mode.media_mode == `MMCR_MEDIA_RSVD;
    mode.sense_override        = ovr_reg;
    mode.far_end_loopback      = felb_reg;
  end

  // Media choice. Fixed codes pick their media; sense codes honour the
  // override, then a lone present media, then the preference. The
  // reserved media code and reserved override select nothing.
  always_comb begin
    sel_next = MMCR_SEL_NONE;
    case (mode.media_mode)
      `MMCR_MEDIA_COPPER: begin
        sel_next = MMCR_SEL_COPPER;
      end
      `MMCR_MEDIA_PTM, `MMCR_MEDIA_1000X, `MMCR_MEDIA_100FX: begin
        sel_next = MMCR_SEL_SERDES;
      end
      `MMCR_MEDIA_SENSE_PTM, `MMCR_MEDIA_SENSE_1000X, `MMCR_MEDIA_SENSE_100FX: begin
        if (ovr_reg == `MMCR_OVR_SERDES) begin
          sel_next = MMCR_SEL_SERDES;
        end else if (ovr_reg == `MMCR_OVR_COPPER) begin
          sel_next = MMCR_SEL_COPPER;
        end else if (ovr_reg == `MMCR_OVR_NORMAL) begin
          if (det_q == 2'h1) begin
            sel_next = MMCR_SEL_COPPER;
          end else if (det_q == 2'h2) begin
            sel_next = MMCR_SEL_SERDES;
          end else begin
            sel_next = mode.copper_preferred ? MMCR_SEL_COPPER : MMCR_SEL_SERDES;
          end
        end
      end
      default: begin
        sel_next = MMCR_SEL_NONE;
      end
    endcase
  end

  // Registered media choice.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      media_sel <= MMCR_SEL_NONE;
    end else begin
      media_sel <= sel_next;
    end
  end

endmodule

// file: tb/mmcr_top_properties.sv
// Concurrent checks on the ports of the media mode control register bank.
`timescale 1ns/1ps

module mmcr_top_properties (
  // Clock and reset.
  input wire logic                      clk_sys,
  input wire logic                      rstn,
  // Management pins and station address.
  input wire logic [4:0]                phy_addr,
  input wire logic                      mdc,
  input wire logic                      mdio_in,
  input wire logic                      mdio_out,
  input wire logic                      mdio_oe_n,
  // Serdes field and media presence.
  input wire logic [1:0]                serdes_cfg,
  input wire logic                      copper_link_up,
  input wire logic                      fiber_signal_detect,
  // Mode outputs.
  input wire mmcr_pkg::mmcr_mode_t      mode,
  input wire mmcr_pkg::mmcr_media_sel_t media_sel,
  input wire logic                      sw_reset_pulse
);
  import mmcr_pkg::*;

  // Everything runs on the system clock and rests while reset is held.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // The acting mode may only move together with the software reset pulse.
  mode_hold_a: assert property (
    $changed({mode.mac_1000bx, mode.copper_preferred, mode.media_mode}) |-> sw_reset_pulse)
    else $error("acting mode changed without a software reset");
  swrst_pulse_a: assert property (sw_reset_pulse |=> !sw_reset_pulse)
    else $error("software reset pulse longer than one cycle");
  // Override and loopback are not sticky, so a software reset clears them.
  nonsticky_clear_a: assert property (
    sw_reset_pulse |=> mode.sense_override == 2'h0 && !mode.far_end_loopback)
    else $error("override or loopback survived a software reset");
  sense_decode_a: assert property (
    mode.automatic_media_sense == (mode.media_mode > 3'h4) && mode.media_mode_reserved == (mode.media_mode == 3'h4))
    else $error("media code decoded wrongly");
  // The media choice is registered, so the mode must stand two cycles first.
  fixed_media_a: assert property (
    (mode.media_mode < 3'h4 && $stable(mode))[*2] |->
      media_sel == (mode.media_mode == 3'h0 ? MMCR_SEL_COPPER : MMCR_SEL_SERDES))
    else $error("fixed media code picked the wrong media");
  reserved_none_a: assert property ((mode.media_mode_reserved && $stable(mode))[*2] |-> media_sel == MMCR_SEL_NONE)
    else $error("reserved media code selected a media");
  sense_force_a: assert property (
    (mode.automatic_media_sense && mode.sense_override inside {2'h1, 2'h2} && $stable(mode))[*2] |->
      media_sel == (mode.sense_override == 2'h1 ? MMCR_SEL_SERDES : MMCR_SEL_COPPER))
    else $error("forced media ignored");
  // Presence pins pass a synchroniser, hence the longer settling run.
  sense_pref_a: assert property (
    (mode.automatic_media_sense && mode.sense_override == 2'h0 && copper_link_up && fiber_signal_detect
      && $stable(mode))[*4] |-> media_sel == (mode.copper_preferred ? MMCR_SEL_COPPER : MMCR_SEL_SERDES))
    else $error("preference ignored with both media present");
  mac_valid_a: assert property ((serdes_cfg != 2'h0)[*4] |-> !mode.mac_1000bx_valid)
    else $error("1000BASE-X marked valid with serdes field set");
  ta_drive_a: assert property ($fell(mdio_oe_n) |-> !mdio_out)
    else $error("turnaround not driven low");

  // Main scenarios seen.
  swrst_c: cover property (sw_reset_pulse);
  read_c: cover property ($fell(mdio_oe_n));
  sense_copper_c: cover property (mode.automatic_media_sense && media_sel == MMCR_SEL_COPPER);
endmodule

bind mmcr_top mmcr_top_properties i_mmcr_top_properties (
  .clk_sys, .rstn, .phy_addr, .mdc, .mdio_in, .mdio_out, .mdio_oe_n, .serdes_cfg,
  .copper_link_up, .fiber_signal_detect, .mode, .media_sel, .sw_reset_pulse
);

// file: tb/mmcr_station.sv
// Management station model that drives frames onto the serial management pins.
`timescale 1ns/1ps

module mmcr_station (
  // Clock.
  input  wire logic clk_sys,
  // Management pins.
  output logic      mdc,
  output wire logic mdio_line,
  input  wire logic dev_out,
  input  wire logic dev_oe_n
);
  logic drv_en  = 1'b0; // Station owns the line when set.
  logic drv_bit = 1'b1; // Level the station puts on the line.

  // The line has a pull-up, so once released it reads high, never a stale bit.
  assign mdio_line = !dev_oe_n ? dev_out : (drv_en ? drv_bit : 1'b1);

  initial mdc = 1'b0;

  // One whole frame; each mdc half lasts six clocks, slow enough for the
  // device synchroniser. Data is sampled just before each rising mdc edge.
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] frm;
    frm = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      drv_en  <= !(op == 2'h2 && i < 18);
      drv_bit <= frm[i];
      mdc     <= 1'b0;
      repeat (6) @(posedge clk_sys);
      if (i < 16) begin
        rd[i] = mdio_line;
      end
      mdc <= 1'b1;
      repeat (6) @(posedge clk_sys);
    end
    drv_en <= 1'b0;
    mdc    <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

// file: tb/mmcr_top_bench.sv
// Self-checking bench for the media mode control register bank.
`timescale 1ns/1ps

module mmcr_top_bench;
  import mmcr_pkg::*;

  localparam logic [4:0] PA = 5'h03; // Station address of the port.

  logic            clk_sys    = 1'b0;
  logic            rstn       = 1'b0;
  logic [1:0]      serdes_cfg = 2'h0;
  logic            cu_up      = 1'b0; // Copper media present.
  logic            fb_sd      = 1'b0; // Fiber media present.
  logic            mdc;
  logic            mdio_line;
  logic            dev_out;
  logic            dev_oe_n;
  logic            swrst;
  mmcr_mode_t      mode;
  mmcr_media_sel_t media_sel;
  int              err_total   = 0;
  int              comparisons = 0;
  int              n_swrst     = 0; // Software reset pulses seen.
  logic [15:0]     rd;

  always #10 clk_sys = ~clk_sys;

  // Count pulses so that a single short pulse is never missed.
  always @(posedge clk_sys) begin
    if (swrst === 1'b1) begin
      n_swrst <= n_swrst + 1;
    end
  end

  mmcr_top i_mmcr_top (
    .clk_sys(clk_sys), .rstn(rstn), .phy_addr(PA), .mdc(mdc), .mdio_in(mdio_line),
    .mdio_out(dev_out), .mdio_oe_n(dev_oe_n), .serdes_cfg(serdes_cfg), .copper_link_up(cu_up),
    .fiber_signal_detect(fb_sd), .mode(mode), .media_sel(media_sel), .sw_reset_pulse(swrst)
  );

  mmcr_station i_mmcr_station (
    .clk_sys(clk_sys), .mdc(mdc), .mdio_line(mdio_line), .dev_out(dev_out), .dev_oe_n(dev_oe_n)
  );

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    i_mmcr_station.xfer(2'h1, PA, ra, d, rd);
  endtask

  task automatic rdc(input logic [4:0] ra, input logic [15:0] e);
    i_mmcr_station.xfer(2'h2, PA, ra, 16'h0000, rd);
    check("read", rd, e);
  endtask

  // Software reset through bit 15 of register 0; exactly one pulse expected.
  task automatic swr();
    int n0;
    n0 = n_swrst;
    wr(5'h00, 16'h8000);
    check("swrst", 16'(n_swrst - n0), 16'h0001);
  endtask

  // Expected mode word, validity bit left out; code above 4 means sensing.
  function automatic logic [15:0] mexp(input logic m, p, input logic [2:0] c, input logic [1:0] o, input logic f);
    return {5'h00, m, 1'b0, p, c, c > 3'h4, c == 3'h4, o, f};
  endfunction

  task automatic cm(input logic [15:0] e, input mmcr_media_sel_t s);
    check("mode", 16'(mode) & 16'h05ff, e);
    check("media_sel", 16'(media_sel), 16'(s));
  endtask

  // Sensing code 7 with an override or presence pattern.
  task automatic amsc(input logic [15:0] d, input logic cu, fb, input mmcr_media_sel_t s);
    cu_up <= cu;
    fb_sd <= fb;
    wr(5'h17, d);
    cm(mexp(1'b0, 1'b0, 3'h7, d[7:6], 1'b0), s);
  endtask

  // A hang is cut short here and reported as a mismatch.
  initial begin
    repeat (95000) @(posedge clk_sys);
    err_total++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdc(5'h17, 16'h0000);
    cm(mexp(1'b0, 1'b0, 3'h0, 2'h0, 1'b0), MMCR_SEL_COPPER);
    wr(5'h17, 16'hffff);
    rdc(5'h17, 16'hc0c8);
    cm(mexp(1'b0, 1'b0, 3'h0, 2'h3, 1'b1), MMCR_SEL_COPPER);
    // Foreign address, bad opcode and an unmapped register change nothing.
    i_mmcr_station.xfer(2'h1, 5'h04, 5'h17, 16'h0000, rd);
    i_mmcr_station.xfer(2'h0, PA, 5'h17, 16'h0000, rd);
    rdc(5'h17, 16'hc0c8);
    wr(5'h05, 16'hffff);
    rdc(5'h05, 16'h0000);
    swr();
    rdc(5'h17, 16'h3f00);
    cm(mexp(1'b1, 1'b1, 3'h7, 2'h0, 1'b0), MMCR_SEL_COPPER);
    check("valid", 16'(mode.mac_1000bx_valid), 16'h0001);
    serdes_cfg <= 2'h2;
    repeat (6) @(posedge clk_sys);
    check("valid", 16'(mode.mac_1000bx_valid), 16'h0000);
    serdes_cfg <= 2'h0;
    swr();
    rdc(5'h17, 16'h3f00);
    cu_up <= 1'b1;
    fb_sd <= 1'b1;
    // Every media code, both media present and fiber preferred.
    for (int c = 0; c < 8; c++) begin
      wr(5'h17, {5'h00, 3'(c), 8'h00});
      swr();
      rdc(5'h17, {5'h00, 3'(c), 8'h00});
      cm(mexp(1'b0, 1'b0, 3'(c), 2'h0, 1'b0), c == 0 ? MMCR_SEL_COPPER : (c == 4 ? MMCR_SEL_NONE : MMCR_SEL_SERDES));
    end
    amsc(16'h0740, 1'b1, 1'b0, MMCR_SEL_SERDES);
    amsc(16'h0780, 1'b0, 1'b1, MMCR_SEL_COPPER);
    amsc(16'h0700, 1'b1, 1'b0, MMCR_SEL_COPPER);
    amsc(16'h0700, 1'b1, 1'b1, MMCR_SEL_SERDES);
    amsc(16'h07c0, 1'b1, 1'b1, MMCR_SEL_NONE);
    wr(5'h17, 16'h0f00);
    swr();
    cm(mexp(1'b0, 1'b1, 3'h7, 2'h0, 1'b0), MMCR_SEL_COPPER);
    wr(5'h17, 16'h0f08);
    cm(mexp(1'b0, 1'b1, 3'h7, 2'h0, 1'b1), MMCR_SEL_COPPER);
    swr();
    cm(mexp(1'b0, 1'b1, 3'h7, 2'h0, 1'b0), MMCR_SEL_COPPER);
    // A hardware reset in mid-run clears even the sticky fields.
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdc(5'h17, 16'h0000);
    cm(mexp(1'b0, 1'b0, 3'h0, 2'h0, 1'b0), MMCR_SEL_COPPER);
    results();
  end
endmodule
